// File: rtl/node_ctrl_pkg.sv
// constants, field layout and carriers for node configuration and reset control
// Function
// - setting lock bit 31 refuses later node configuration register writes
// - node configuration bit 0 selects header size: 0 three-byte, 1 one-byte; resets zero
// - readable writable 16-bit node identifier in bits 15:0, resets zero, no effect
// - two reset scopes: whole-system reset and processor-tile-only reset
// - system reset starts on reset pin low, any brown-out, or watchdog expiry
// - tile-only reset starts on sleep sequence and on any clock source change
// - system reset held for 524,288 oscillator clock cycles from an internal counter
// - reset and mode control bit 3 is USB register access enable, resets zero
// - bit 2 enables USB block; zero disables it and resets its registers
// - writing one to write-only bit 1 starts a tile reset, bit self-clears
// - writing one to write-only bit 0 starts self-clearing system reset restoring registers
// - a write setting either reset bit sends no response, even if requested
// - bits 17:16 drive processor mode pins; bit 24 tristates those pins
// - registers are served through configuration read and write transactions
package node_ctrl_pkg;

	// ****************************************
	// register numbers
	// ****************************************
	localparam logic [7:0] REG_NODE_CFG = 8'h04;
	localparam logic [7:0] REG_NODE_ID = 8'h05;
	localparam logic [7:0] REG_RST_MODE = 8'h50;

	// ****************************************
	// field positions
	// ****************************************
	localparam int NC_LOCK_BIT = 31;
	localparam int NC_HDR_BIT = 0;
	localparam int NID_MSB = 15;
	localparam int RM_TRI_BIT = 24;
	localparam int RM_MODE_MSB = 17;
	localparam int RM_MODE_LSB = 16;
	localparam int RM_USB_ACC_BIT = 3;
	localparam int RM_USB_EN_BIT = 2;
	localparam int RM_TILE_RST_BIT = 1;
	localparam int RM_SYS_RST_BIT = 0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic LOCK_RST = 1'b0;
	localparam logic HDR_RST = 1'b0;
	localparam logic [15:0] NID_RST = 16'h0000;
	localparam logic TRI_RST = 1'b0;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic USB_ACC_RST = 1'b0;
	localparam logic USB_EN_RST = 1'b0;

	// ****************************************
	// reset lengths in oscillator cycles
	// ****************************************
	localparam int SYS_RST_CYCLES_DEF = 524288;
	localparam int TILE_RST_CYCLES_DEF = 16;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic valid;
		logic write;
		logic want_rsp;
		logic [7:0] num;
		logic [31:0] wdata;
	} cfg_req_s;

	typedef struct packed {
		logic valid;
		logic ack;
		logic [31:0] rdata;
	} cfg_rsp_s;

endpackage

// File: rtl/reset_stretch.sv
// counter that holds a reset active for a fixed number of clock cycles
`timescale 1ns/100ps
`default_nettype none
module reset_stretch #(
	parameter int CYCLES = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	output logic active
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);
	localparam logic [CW-1:0] ONE = CW'(1);

	generate
		if (CYCLES < 1)
		begin : g_bad
			$error("reset_stretch needs CYCLES of at least one");
		end
	endgenerate

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic active_nxt;

	// a new start while running reloads, so the reset always lasts CYCLES after the last cause
	assign cnt_nxt = start ? LOAD : ((cnt_r != '0) ? cnt_r - ONE : cnt_r);
	assign active_nxt = start | (cnt_r > ONE);

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cnt_r <= '0;
			active <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			active <= active_nxt;
		end
	end
endmodule // reset_stretch
`default_nettype wire

// File: rtl/node_config_reset_control.sv
// node configuration registers, reset sequencing, usb enables and mode pins
`timescale 1ns/100ps
`default_nettype none
module node_config_reset_control #(
	parameter int SYS_RST_CYCLES = node_ctrl_pkg::SYS_RST_CYCLES_DEF,
	parameter int TILE_RST_CYCLES = node_ctrl_pkg::TILE_RST_CYCLES_DEF
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire node_ctrl_pkg::cfg_req_s cfg_req,
	output node_ctrl_pkg::cfg_rsp_s cfg_rsp,
	input wire logic ext_rst_pin_n,
	input wire logic brownout_pin,
	input wire logic watchdog_expired,
	input wire logic sleep_seq,
	input wire logic clk_src_change,
	output logic sys_reset,
	output logic tile_reset,
	output logic cfg_lock,
	output logic header_1byte,
	output logic usb_reg_access_en,
	output logic usb_block_en,
	output logic usb_if_reset,
	output logic [1:0] mode_pins_out,
	output logic mode_pins_oe_n
);
	import node_ctrl_pkg::*;

	generate
		if (SYS_RST_CYCLES < 2 || TILE_RST_CYCLES < 1)
		begin : g_bad
			$error("reset lengths out of range");
		end
	endgenerate

	// ****************************************
	// pin synchronisers
	// ****************************************
	// index 0 is the reset pin, index 1 the brown-out pin; both start in the asserted
	// reading so that leaving block reset runs one full system reset
	localparam int PINS = 2;
	localparam logic [PINS-1:0] PIN_SYNC_RST = 2'h2;
	wire [PINS-1:0] pin_raw = {brownout_pin, ext_rst_pin_n};
	wire [PINS-1:0] pin_sync;

	// one two-stage chain per pin; only the second stage feeds any logic
	generate
		for (genvar i = 0; i < PINS; i++)
		begin : g_pin_sync
			logic meta_r;
			logic sync_r;

			always_ff @(posedge clock)
			begin
				if (!rst_n)
				begin
					meta_r <= PIN_SYNC_RST[i];
					sync_r <= PIN_SYNC_RST[i];
				end
				else
				begin
					meta_r <= pin_raw[i];
					sync_r <= meta_r;
				end
			end

			assign pin_sync[i] = sync_r;
		end
	endgenerate

	// ****************************************
	// request decode
	// ****************************************
	function automatic logic hit(input logic [7:0] num, input logic [7:0] target);
		hit = (num == target);
	endfunction

	logic sys_act;
	logic tile_act;
	logic lock_r;
	logic hdr_r;
	logic [15:0] nid_r;
	logic tri_r;
	logic [1:0] mode_r;
	logic usb_acc_r;
	logic usb_en_r;

	// requests are ignored while the system reset holds the node
	wire req_ok = cfg_req.valid & ~sys_act;
	wire wr = req_ok & cfg_req.write;
	wire rd = req_ok & ~cfg_req.write;
	wire hit_nc = hit(cfg_req.num, REG_NODE_CFG);
	wire hit_nid = hit(cfg_req.num, REG_NODE_ID);
	wire hit_rm = hit(cfg_req.num, REG_RST_MODE);
	wire mapped = hit_nc | hit_nid | hit_rm;
	wire wr_nc = wr & hit_nc & ~lock_r;
	wire wr_nc_refused = wr & hit_nc & lock_r;
	wire wr_nid = wr & hit_nid;
	wire wr_rm = wr & hit_rm;
	wire soft_sys = wr_rm & cfg_req.wdata[RM_SYS_RST_BIT];
	wire soft_tile = wr_rm & cfg_req.wdata[RM_TILE_RST_BIT];

	// ****************************************
	// reset sources
	// ****************************************
	wire pin_rst = ~pin_sync[0];
	wire bo_rst = pin_sync[1];
	wire sys_start = pin_rst | bo_rst | watchdog_expired | soft_sys;
	wire tile_start = sleep_seq | clk_src_change | soft_tile;
	// configuration goes back to its initial values while the system reset runs
	wire cfg_clear = sys_start | sys_act;

	reset_stretch #(
		.CYCLES(SYS_RST_CYCLES)
	) u_sys_stretch (
		.clock(clock),
		.rst_n(rst_n),
		.start(sys_start),
		.active(sys_act)
	);

	reset_stretch #(
		.CYCLES(TILE_RST_CYCLES)
	) u_tile_stretch (
		.clock(clock),
		.rst_n(rst_n),
		.start(tile_start),
		.active(tile_act)
	);

	// system scope contains the tile, so a system reset also holds the tile
	wire sys_reset_nxt = sys_act;
	wire tile_reset_nxt = tile_act | sys_act;

	// ****************************************
	// register next values
	// ****************************************
	// reserved bits are simply not stored, so writes to them vanish
	wire lock_nxt = cfg_clear ? LOCK_RST : (wr_nc ? cfg_req.wdata[NC_LOCK_BIT] : lock_r);
	wire hdr_nxt = cfg_clear ? HDR_RST : (wr_nc ? cfg_req.wdata[NC_HDR_BIT] : hdr_r);
	wire [15:0] nid_nxt = cfg_clear ? NID_RST : (wr_nid ? cfg_req.wdata[NID_MSB:0] : nid_r);
	wire tri_nxt = cfg_clear ? TRI_RST : (wr_rm ? cfg_req.wdata[RM_TRI_BIT] : tri_r);
	wire [1:0] mode_nxt = cfg_clear ? MODE_RST
		: (wr_rm ? cfg_req.wdata[RM_MODE_MSB:RM_MODE_LSB] : mode_r);
	wire usb_acc_nxt = cfg_clear ? USB_ACC_RST
		: (wr_rm ? cfg_req.wdata[RM_USB_ACC_BIT] : usb_acc_r);
	wire usb_en_nxt = cfg_clear ? USB_EN_RST
		: (wr_rm ? cfg_req.wdata[RM_USB_EN_BIT] : usb_en_r);

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			lock_r <= LOCK_RST;
			hdr_r <= HDR_RST;
		end
		else
		begin
			lock_r <= lock_nxt;
			hdr_r <= hdr_nxt;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			nid_r <= NID_RST;
		end
		else
		begin
			nid_r <= nid_nxt;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			tri_r <= TRI_RST;
			mode_r <= MODE_RST;
		end
		else
		begin
			tri_r <= tri_nxt;
			mode_r <= mode_nxt;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			usb_acc_r <= USB_ACC_RST;
			usb_en_r <= USB_EN_RST;
		end
		else
		begin
			usb_acc_r <= usb_acc_nxt;
			usb_en_r <= usb_en_nxt;
		end
	end

	// ****************************************
	// read data
	// ****************************************
	function automatic logic [31:0] read_word(input logic [7:0] num);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (hit(num, REG_NODE_CFG))
		begin
			w[NC_LOCK_BIT] = lock_r;
			w[NC_HDR_BIT] = hdr_r;
		end
		else if (hit(num, REG_NODE_ID))
		begin
			w[NID_MSB:0] = nid_r;
		end
		else if (hit(num, REG_RST_MODE))
		begin
			// the reset bits are write-only and read back as zero
			w[RM_TRI_BIT] = tri_r;
			w[RM_MODE_MSB:RM_MODE_LSB] = mode_r;
			w[RM_USB_ACC_BIT] = usb_acc_r;
			w[RM_USB_EN_BIT] = usb_en_r;
		end
		read_word = w;
	endfunction

	// ****************************************
	// response
	// ****************************************
	// a write that starts a reset never answers: the node is going away under it
	wire rst_bits_wr = soft_sys | soft_tile;
	wire rsp_v_nxt = rd | (wr & cfg_req.want_rsp & ~rst_bits_wr);
	wire rsp_ack_nxt = mapped & ~wr_nc_refused;
	wire [31:0] rsp_data_nxt = rd ? read_word(cfg_req.num) : 32'h0000_0000;
	cfg_rsp_s rsp_nxt;
	assign rsp_nxt = '{valid: rsp_v_nxt, ack: rsp_v_nxt & rsp_ack_nxt, rdata: rsp_data_nxt};

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cfg_rsp <= '0;
		end
		else
		begin
			cfg_rsp <= rsp_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			sys_reset <= 1'b0;
		end
		else
		begin
			sys_reset <= sys_reset_nxt;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			tile_reset <= 1'b0;
		end
		else
		begin
			tile_reset <= tile_reset_nxt;
		end
	end

	// copies give every output its own flop at the same timing as the register
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cfg_lock <= LOCK_RST;
			header_1byte <= HDR_RST;
		end
		else
		begin
			cfg_lock <= lock_nxt;
			header_1byte <= hdr_nxt;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			usb_reg_access_en <= USB_ACC_RST;
			usb_block_en <= USB_EN_RST;
			usb_if_reset <= ~USB_EN_RST;
		end
		else
		begin
			usb_reg_access_en <= usb_acc_nxt;
			usb_block_en <= usb_en_nxt;
			usb_if_reset <= ~usb_en_nxt;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			mode_pins_out <= MODE_RST;
			mode_pins_oe_n <= TRI_RST;
		end
		else
		begin
			mode_pins_out <= mode_nxt;
			mode_pins_oe_n <= tri_nxt;
		end
	end
endmodule // node_config_reset_control
`default_nettype wire

// File: dv/node_ctrl_assertions.sv
// checker for node configuration and reset control
`timescale 1ns/100ps
`default_nettype none
module node_ctrl_assertions #(
	parameter int SYS_RST_CYCLES = node_ctrl_pkg::SYS_RST_CYCLES_DEF,
	parameter int TILE_RST_CYCLES = node_ctrl_pkg::TILE_RST_CYCLES_DEF
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire node_ctrl_pkg::cfg_req_s cfg_req,
	input wire node_ctrl_pkg::cfg_rsp_s cfg_rsp,
	input wire logic ext_rst_pin_n,
	input wire logic brownout_pin,
	input wire logic watchdog_expired,
	input wire logic sleep_seq,
	input wire logic clk_src_change,
	input wire logic sys_reset,
	input wire logic tile_reset,
	input wire logic cfg_lock,
	input wire logic header_1byte,
	input wire logic usb_reg_access_en,
	input wire logic usb_block_en,
	input wire logic usb_if_reset,
	input wire logic [1:0] mode_pins_out,
	input wire logic mode_pins_oe_n
);
	import node_ctrl_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ****
	// run length of system reset
	// ****
	// power-on reset may restart a few cycles, so only a floor is asserted
	int len_r;
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			len_r <= 0;
		else
			len_r <= sys_reset ? len_r + 1 : 0;
	end
	rd_answer_a: assert property ((cfg_req.valid && !cfg_req.write && !sys_reset)
		##1 !sys_reset |-> cfg_rsp.valid) else $error("read got no answer");
	no_rsp_rst_a: assert property (cfg_req.valid && cfg_req.write
		&& cfg_req.num == REG_RST_MODE
		&& (cfg_req.wdata[RM_SYS_RST_BIT] || cfg_req.wdata[RM_TILE_RST_BIT])
		|=> !cfg_rsp.valid) else $error("reset write answered");
	sys_len_a: assert property ($fell(sys_reset) |-> len_r >= SYS_RST_CYCLES)
		else $error("system reset too short");
	tile_cover_a: assert property (sys_reset |-> tile_reset) else $error("tile not in reset");
	wdog_start_a: assert property (watchdog_expired |-> ##2 sys_reset)
		else $error("watchdog did not reset");
	pin_start_a: assert property ($fell(ext_rst_pin_n) || $rose(brownout_pin)
		|-> ##[1:4] sys_reset) else $error("pin did not reset");
	tile_start_a: assert property (sleep_seq || clk_src_change |-> ##2 tile_reset)
		else $error("tile reset missing");
	usb_rst_a: assert property (usb_if_reset != usb_block_en) else $error("usb reset wrong");
	// a reset starting with the write clears the lock an edge before sys_reset shows it
	lock_hold_a: assert property ((cfg_req.valid && cfg_req.write && cfg_lock
		&& cfg_req.num == REG_NODE_CFG && !sys_reset) ##1 !sys_reset ##1 !sys_reset
		|-> $past(cfg_lock) && $past(header_1byte) == $past(header_1byte, 2))
		else $error("locked register changed");
	sys_clear_a: assert property (sys_reset |-> !cfg_lock && !header_1byte
		&& !usb_block_en && mode_pins_out == 2'h0) else $error("registers kept in reset");
	cover property ($fell(sys_reset));
	cover property ($rose(cfg_lock));
	cover property ($rose(tile_reset) && !sys_reset);
endmodule // node_ctrl_assertions
bind node_config_reset_control node_ctrl_assertions #(.SYS_RST_CYCLES(SYS_RST_CYCLES),
	.TILE_RST_CYCLES(TILE_RST_CYCLES)) node_ctrl_assertions_inst (.clock(clock), .rst_n(rst_n),
	.cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .ext_rst_pin_n(ext_rst_pin_n),
	.brownout_pin(brownout_pin), .watchdog_expired(watchdog_expired), .sleep_seq(sleep_seq),
	.clk_src_change(clk_src_change), .sys_reset(sys_reset), .tile_reset(tile_reset),
	.cfg_lock(cfg_lock), .header_1byte(header_1byte), .usb_reg_access_en(usb_reg_access_en),
	.usb_block_en(usb_block_en), .usb_if_reset(usb_if_reset), .mode_pins_out(mode_pins_out),
	.mode_pins_oe_n(mode_pins_oe_n));
`default_nettype wire

// File: dv/tb_node_config_reset_control.sv
// self-checking bench for node configuration and reset control
`timescale 1ns/100ps
`default_nettype none
module tb_node_config_reset_control;
	import node_ctrl_pkg::*;
	// ****
	// short reset counts keep the run brief
	// ****
	localparam int SYS = 40;
	localparam int TILE = 16;
	logic clock, rst_n, pin_n, bo, wd, slp, csc;
	logic sys_rst, tile_rst, lock, hdr, acc, usb_en, usb_rst, oe_n;
	logic [1:0] mode;
	cfg_req_s req;
	cfg_rsp_s rsp;
	int err_count, comparisons;
	node_config_reset_control #(.SYS_RST_CYCLES(SYS), .TILE_RST_CYCLES(TILE))
		node_config_reset_control_inst (.clock(clock), .rst_n(rst_n), .cfg_req(req),
		.cfg_rsp(rsp), .ext_rst_pin_n(pin_n), .brownout_pin(bo), .watchdog_expired(wd),
		.sleep_seq(slp), .clk_src_change(csc), .sys_reset(sys_rst), .tile_reset(tile_rst),
		.cfg_lock(lock), .header_1byte(hdr), .usb_reg_access_en(acc), .usb_block_en(usb_en),
		.usb_if_reset(usb_rst), .mode_pins_out(mode), .mode_pins_oe_n(oe_n));
	initial
	begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end
	task automatic end_of_test;
		if (err_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// ****
	// one request with a response always asked for
	// ****
	task automatic xfer(input logic w, input logic [7:0] n, input logic [31:0] d,
		input logic v, input logic a, input logic [31:0] rd);
		req = '{1'h1, w, 1'h1, n, d};
		@(posedge clock) #1;
		chk(32'({rsp.valid, rsp.ack}), 32'({v, a}));
		if (v)
			chk(rsp.rdata, rd);
		req.valid = 1'h0;
		@(posedge clock) #1;
	endtask
	task automatic meas(input logic s, input int exp);
		int n;
		n = 0;
		repeat (8)
			if ((s ? sys_rst : tile_rst) !== 1'h1)
				@(posedge clock) #1;
		chk(32'(sys_rst), 32'(s));
		while ((s ? sys_rst : tile_rst) === 1'h1 && n < 200)
		begin
			n++;
			@(posedge clock) #1;
		end
		if (exp > 0)
			chk(32'(n), 32'(exp));
		@(posedge clock) #1;
	endtask
	task automatic t_regs;
		xfer(1'h0, REG_NODE_CFG, 32'h0, 1'h1, 1'h1, 32'h0);
		xfer(1'h0, REG_NODE_ID, 32'h0, 1'h1, 1'h1, 32'h0);
		xfer(1'h0, REG_RST_MODE, 32'h0, 1'h1, 1'h1, 32'h0);
		chk(32'({usb_rst, oe_n, mode}), 32'h8);
		xfer(1'h1, REG_NODE_ID, 32'hffffffff, 1'h1, 1'h1, 32'h0);
		xfer(1'h0, REG_NODE_ID, 32'h0, 1'h1, 1'h1, 32'h0000ffff);
		xfer(1'h1, REG_RST_MODE, 32'hfffffffc, 1'h1, 1'h1, 32'h0);
		xfer(1'h0, REG_RST_MODE, 32'h0, 1'h1, 1'h1, 32'h0103000c);
		chk(32'({usb_rst, oe_n, mode, acc, usb_en}), 32'h1f);
		xfer(1'h1, REG_RST_MODE, 32'h0, 1'h1, 1'h1, 32'h0);
		chk(32'({usb_rst, usb_en}), 32'h2);
		xfer(1'h0, 8'h51, 32'h0, 1'h1, 1'h0, 32'h0);
		xfer(1'h1, 8'h80, 32'h1, 1'h1, 1'h0, 32'h0);
	endtask
	task automatic t_lock;
		xfer(1'h1, REG_NODE_CFG, 32'h80000001, 1'h1, 1'h1, 32'h0);
		chk(32'({lock, hdr}), 32'h3);
		xfer(1'h1, REG_NODE_CFG, 32'h0, 1'h1, 1'h0, 32'h0);
		xfer(1'h0, REG_NODE_CFG, 32'h0, 1'h1, 1'h1, 32'h80000001);
	endtask
	task automatic t_soft;
		xfer(1'h1, REG_RST_MODE, 32'h6, 1'h0, 1'h0, 32'h0);
		chk(32'(usb_en), 32'h1);
		meas(1'h0, TILE);
		xfer(1'h1, REG_RST_MODE, 32'h1, 1'h0, 1'h0, 32'h0);
		meas(1'h1, SYS);
		xfer(1'h0, REG_NODE_CFG, 32'h0, 1'h1, 1'h1, 32'h0);
		xfer(1'h0, REG_RST_MODE, 32'h0, 1'h1, 1'h1, 32'h0);
	endtask
	// pin, brown-out, watchdog, sleep, clock change, one at a time
	task automatic t_src;
		for (int i = 0; i < 5; i++)
		begin
			{pin_n, bo, wd, slp, csc} = (5'h10 >> i) ^ 5'h10;
			@(posedge clock) #1;
			{pin_n, bo, wd, slp, csc} = 5'h10;
			meas(i < 3, i < 3 ? SYS : TILE);
		end
	endtask
	initial
	begin
		err_count = 0;
		comparisons = 0;
		rst_n = 1'h0;
		{pin_n, bo, wd, slp, csc} = 5'h10;
		req = '0;
		repeat (6) @(posedge clock);
		#1 rst_n = 1'h1;
		meas(1'h1, 0);
		t_regs;
		t_lock;
		t_soft;
		t_src;
		end_of_test;
	end
	initial
	begin
		#(25 * 4000);
		err_count++;
		end_of_test;
	end
endmodule // tb_node_config_reset_control
`default_nettype wire
